// file: table_selector.sv
// Conditional table selector: picks one of three lookup-table outputs by conditions.
// Assumes block outputs arrive as a flat source array on the same clock.
// Behaviour
// - Inactive unless enable is set; enable resets false.
// - Forward selected table's output unchanged; up to three tables.
// - Evaluate tables in ascending order; stop at first selected.
// - Default-table combiner selects its table immediately.
// - Three tables, three conditions; first argument chosen by type and number.
// - Second argument is a block output or a user constant.
// - Operator defaults to equal; changed only with two valid arguments.
// - Operator codes 0 equal through 5 less-or-equal.
// - Arguments reset to unused, making result not-applicable.
// - Result 0 false, 1 true, 2 error, 3 not-applicable.
// - Combiner codes 0 default through 4 OR-then-AND.
// - AND-all rejects false or error; not-applicable counts true.
// - OR-all selects on any true; others count false.
// - Code 3 selects on (one and two) or three true.
// - Code 4 selects on three true with one or two true.
// - Reset combiners: tables one, two AND-all; table three default.
// - Selected table with no axis source gives not-available output.
// - No scaling between table value and output.
module table_selector #(
  parameter int SOURCE_COUNT = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Configuration strobe and values
  input wire logic config_write_i,
  input wire logic enable_i,
  input wire table_selector_pkg::table_cfg_type table_cfg_i [`TABLE_COUNT],
  input wire logic [2:0] combiner_i [`TABLE_COUNT],
  // Block outputs and lookup tables
  input wire table_selector_pkg::signal_type source_i [SOURCE_COUNT],
  input wire table_selector_pkg::signal_type table_i [`TABLE_COUNT],
  input wire logic [`TABLE_COUNT-1:0] table_axis_valid_i,
  // Selector output
  output table_selector_pkg::signal_type result_o,
  output logic [1:0] selected_table_o,
  output logic enabled_o
);

  // ****************************************
  // Configuration store
  // ****************************************
  logic enable_reg;
  logic enable_next;
  table_selector_pkg::table_cfg_type cfg_reg [`TABLE_COUNT];
  table_selector_pkg::table_cfg_type cfg_next [`TABLE_COUNT];
  logic [2:0] combiner_reg [`TABLE_COUNT];
  logic [2:0] combiner_next [`TABLE_COUNT];

  function automatic logic source_used(input logic [`SOURCE_TYPE_WIDTH-1:0] kind);
    source_used = (kind != `SOURCE_NOT_USED);
  endfunction

  // Operators other than equality mean nothing without two real arguments.
  function automatic table_selector_pkg::condition_cfg_type sanitize(
    input table_selector_pkg::condition_cfg_type cfg
  );
    table_selector_pkg::condition_cfg_type kept;
    kept = cfg;
    if (!(source_used(cfg.first_type) && source_used(cfg.second_type))) begin
      kept.operator_code = `OP_EQUAL;
    end
    sanitize = kept;
  endfunction

  always_comb begin
    enable_next = enable_reg;
    if (config_write_i) begin
      enable_next = enable_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      enable_reg <= 1'h0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_comb begin
    cfg_next = cfg_reg;
    if (config_write_i) begin
      for (int t = 0; t < `TABLE_COUNT; t++) begin
        for (int c = 0; c < `CONDITION_COUNT; c++) begin
          cfg_next[t][c] = sanitize(table_cfg_i[t][c]);
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int t = 0; t < `TABLE_COUNT; t++) begin
        for (int c = 0; c < `CONDITION_COUNT; c++) begin
          cfg_reg[t][c] <= '0;
          cfg_reg[t][c].first_type <= `SOURCE_NOT_USED;
          cfg_reg[t][c].second_type <= `SOURCE_NOT_USED;
          cfg_reg[t][c].operator_code <= `OP_EQUAL;
        end
      end
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  always_comb begin
    combiner_next = combiner_reg;
    if (config_write_i) begin
      combiner_next = combiner_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int t = 0; t < `TABLE_COUNT; t++) begin
        combiner_reg[t] <= `COMBINE_AND_ALL;
      end
      combiner_reg[`TABLE_COUNT-1] <= `COMBINE_DEFAULT;
    end else begin
      combiner_reg <= combiner_next;
    end
  end

  // ****************************************
  // Condition evaluation
  // ****************************************
  // Source number indexes the source array; the type code only marks whether
  // the argument is used or is the constant. Out-of-range numbers read as unavailable.
  function automatic table_selector_pkg::signal_type pick_source(
    input logic [`SOURCE_NUMBER_WIDTH-1:0] number,
    input table_selector_pkg::signal_type sources [SOURCE_COUNT]
  );
    table_selector_pkg::signal_type picked;
    picked = '0;
    for (int s = 0; s < SOURCE_COUNT; s++) begin
      if (number == s[`SOURCE_NUMBER_WIDTH-1:0]) begin
        picked = sources[s];
      end
    end
    pick_source = picked;
  endfunction

  function automatic logic compare(
    input logic [2:0] op,
    input logic [`DATA_WIDTH-1:0] a,
    input logic [`DATA_WIDTH-1:0] b
  );
    case (op)
      `OP_EQUAL: compare = (a == b);
      `OP_NOT_EQUAL: compare = (a != b);
      `OP_GREATER: compare = (a > b);
      `OP_GREATER_EQUAL: compare = (a >= b);
      `OP_LESS: compare = (a < b);
      `OP_LESS_EQUAL: compare = (a <= b);
      default: compare = 1'h0;
    endcase
  endfunction

  // Classifies one condition once both arguments are resolved.
  function automatic logic [1:0] classify(
    input table_selector_pkg::condition_cfg_type cfg,
    input table_selector_pkg::signal_type first,
    input table_selector_pkg::signal_type second
  );
    logic [1:0] outcome;
    // Unavailability outranks error so an unused argument always reads N/A.
    if (!source_used(cfg.first_type) || !source_used(cfg.second_type) ||
        !first.available || !second.available) begin
      outcome = `RESULT_NOT_APPLICABLE;
    end else if (first.error || second.error) begin
      outcome = `RESULT_ERROR;
    end else if (compare(cfg.operator_code, first.value, second.value)) begin
      outcome = `RESULT_TRUE;
    end else begin
      outcome = `RESULT_FALSE;
    end
    classify = outcome;
  endfunction

  // A constant stands in for a block output on the second argument only.
  function automatic table_selector_pkg::signal_type second_source(
    input table_selector_pkg::condition_cfg_type cfg,
    input table_selector_pkg::signal_type sources [SOURCE_COUNT]
  );
    table_selector_pkg::signal_type chosen;
    chosen = pick_source(cfg.second_number, sources);
    if (cfg.second_type == `SOURCE_CONSTANT) begin
      chosen.value = cfg.constant_value;
      chosen.error = 1'h0;
      chosen.available = 1'h1;
    end
    second_source = chosen;
  endfunction

  logic [1:0] result [`TABLE_COUNT][`CONDITION_COUNT];

  generate
    for (genvar t = 0; t < `TABLE_COUNT; t++) begin : g_table
      for (genvar c = 0; c < `CONDITION_COUNT; c++) begin : g_cond
        table_selector_pkg::signal_type first_arg;
        table_selector_pkg::signal_type second_arg;
        always_comb begin
          first_arg = pick_source(cfg_reg[t][c].first_number, source_i);
          second_arg = second_source(cfg_reg[t][c], source_i);
          result[t][c] = classify(cfg_reg[t][c], first_arg, second_arg);
        end
      end
    end
  endgenerate

  // ****************************************
  // Table combiner
  // ****************************************
  function automatic logic table_hit(
    input logic [2:0] code,
    input logic [1:0] first,
    input logic [1:0] second,
    input logic [1:0] third
  );
    logic t1;
    logic t2;
    logic t3;
    logic p1;
    logic p2;
    logic p3;
    t1 = (first == `RESULT_TRUE);
    t2 = (second == `RESULT_TRUE);
    t3 = (third == `RESULT_TRUE);
    p1 = t1 || (first == `RESULT_NOT_APPLICABLE);
    p2 = t2 || (second == `RESULT_NOT_APPLICABLE);
    p3 = t3 || (third == `RESULT_NOT_APPLICABLE);
    case (code)
      `COMBINE_DEFAULT: table_hit = 1'h1;
      `COMBINE_AND_ALL: table_hit = p1 && p2 && p3;
      `COMBINE_OR_ALL: table_hit = t1 || t2 || t3;
      `COMBINE_AND_OR: table_hit = (t1 && t2) || t3;
      `COMBINE_OR_AND: table_hit = (t1 || t2) && t3;
      default: table_hit = 1'h0;
    endcase
  endfunction

  logic [`TABLE_COUNT-1:0] hit;

  always_comb begin
    for (int t = 0; t < `TABLE_COUNT; t++) begin
      hit[t] = table_hit(combiner_reg[t], result[t][0], result[t][1], result[t][2]);
    end
  end

  // Lowest index wins, so a table placed after a default one is never reached.
  function automatic logic [1:0] first_hit(input logic [`TABLE_COUNT-1:0] hits);
    logic [1:0] found;
    found = `NO_TABLE;
    for (int t = `TABLE_COUNT - 1; t >= 0; t--) begin
      if (hits[t]) begin
        found = t[1:0];
      end
    end
    first_hit = found;
  endfunction

  // ****************************************
  // Priority selection and output
  // ****************************************
  logic [1:0] pick;
  table_selector_pkg::signal_type result_next;
  table_selector_pkg::signal_type result_reg;
  logic [1:0] selected_next;
  logic [1:0] selected_reg;

  always_comb begin
    pick = first_hit(hit);
    result_next = '0;
    selected_next = `NO_TABLE;
    if (enable_reg && pick != `NO_TABLE) begin
      selected_next = pick;
      result_next = table_i[pick];
      if (!table_axis_valid_i[pick]) begin
        result_next.available = 1'h0;
      end
    end else if (enable_reg) begin
      result_next.available = 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      result_reg <= '0;
      selected_reg <= `NO_TABLE;
    end else begin
      result_reg <= result_next;
      selected_reg <= selected_next;
    end
  end

  // ****************************************
  // Output ports
  // ****************************************
  assign result_o = result_reg;
  assign selected_table_o = selected_reg;
  assign enabled_o = enable_reg;

endmodule

// file: table_selector_asserts.sv
// Port-level checker for the table selector, bound into every instance.
// Assumes one clock domain with a synchronous active-high reset.
`include "table_selector_cfg.svh"
module table_selector_asserts (
  // Clock, reset and configuration
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic config_write_i,
  input wire logic enable_i,
  input wire logic [2:0] combiner_i [`TABLE_COUNT],
  // Tables
  input wire table_selector_pkg::signal_type table_i [`TABLE_COUNT],
  input wire logic [`TABLE_COUNT-1:0] table_axis_valid_i,
  // Outputs
  input wire table_selector_pkg::signal_type result_o,
  input wire logic [1:0] selected_table_o,
  input wire logic enabled_o
);
  table_selector_pkg::signal_type table_reg [`TABLE_COUNT];
  logic [`TABLE_COUNT-1:0] axis_reg;
  logic [2:0] last_combiner_reg;
  always_ff @(posedge clock_i) begin
    table_reg <= table_i;
    axis_reg <= table_axis_valid_i;
    if (sys_rst_i) begin
      last_combiner_reg <= `COMBINE_DEFAULT;
    end else if (config_write_i) begin
      last_combiner_reg <= combiner_i[`TABLE_COUNT-1];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_write_on;
    config_write_i && enable_i;
  endsequence
  sequence s_write_off;
    config_write_i && !enable_i;
  endsequence
  property p_turn_on;
    s_write_on |=> enabled_o;
  endproperty
  property p_turn_off;
    s_write_off |=> !enabled_o ##1 (selected_table_o == `NO_TABLE && !result_o.available);
  endproperty
  property p_hold;
    !config_write_i |=> $stable(enabled_o);
  endproperty
  property p_reset_out;
    $fell(sys_rst_i) |-> !enabled_o && selected_table_o == `NO_TABLE && result_o == '0;
  endproperty
  property p_gated;
    selected_table_o != `NO_TABLE |-> $past(enabled_o);
  endproperty
  property p_mirror;
    selected_table_o != `NO_TABLE |-> result_o.value == table_reg[selected_table_o].value
      && result_o.error == table_reg[selected_table_o].error;
  endproperty
  property p_axis;
    selected_table_o != `NO_TABLE |-> result_o.available ==
      (axis_reg[selected_table_o] && table_reg[selected_table_o].available);
  endproperty
  property p_no_table;
    selected_table_o == `NO_TABLE |-> !result_o.available;
  endproperty
  property p_default_last;
    enabled_o && last_combiner_reg == `COMBINE_DEFAULT |=> selected_table_o != `NO_TABLE;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("enable not loaded");
  a_turn_off: assert property (p_turn_off) else $error("disable not honoured");
  a_hold: assert property (p_hold) else $error("enable moved without write");
  a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
  a_gated: assert property (p_gated) else $error("selection while disabled");
  a_mirror: assert property (p_mirror) else $error("output not mirrored");
  a_axis: assert property (p_axis) else $error("availability wrong");
  a_no_table: assert property (p_no_table) else $error("no table yet available");
  a_default_last: assert property (p_default_last) else $error("default missed");
endmodule
bind table_selector table_selector_asserts u_asserts (
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .config_write_i(config_write_i),
  .enable_i(enable_i),
  .combiner_i(combiner_i),
  .table_i(table_i),
  .table_axis_valid_i(table_axis_valid_i),
  .result_o(result_o),
  .selected_table_o(selected_table_o),
  .enabled_o(enabled_o)
);

// file: table_selector_cfg.svh
// Constants for the conditional table selector: codes, field widths and reset values.
// Assumes inclusion by bare name from the package, the checker, the bench and the table model.
`ifndef TABLE_SELECTOR_CFG_SVH
`define TABLE_SELECTOR_CFG_SVH

// ****************************************
// Condition operator codes
// ****************************************
`define OP_EQUAL 3'h0
`define OP_NOT_EQUAL 3'h1
`define OP_GREATER 3'h2
`define OP_GREATER_EQUAL 3'h3
`define OP_LESS 3'h4
`define OP_LESS_EQUAL 3'h5

// ****************************************
// Condition result codes
// ****************************************
`define RESULT_FALSE 2'h0
`define RESULT_TRUE 2'h1
`define RESULT_ERROR 2'h2
`define RESULT_NOT_APPLICABLE 2'h3

// ****************************************
// Combiner codes
// ****************************************
`define COMBINE_DEFAULT 3'h0
`define COMBINE_AND_ALL 3'h1
`define COMBINE_OR_ALL 3'h2
`define COMBINE_AND_OR 3'h3
`define COMBINE_OR_AND 3'h4

// ****************************************
// Source codes and field widths
// ****************************************
`define SOURCE_NOT_USED 4'h0
`define SOURCE_CONSTANT 4'h1
`define SOURCE_TYPE_WIDTH 4
`define SOURCE_NUMBER_WIDTH 4
`define DATA_WIDTH 16
`define TABLE_COUNT 3
`define CONDITION_COUNT 3
`define NO_TABLE 2'h3

`endif

// file: table_selector_pkg.sv
// Types shared by the conditional table selector and its bench.
// Assumes the configuration header is on the include path.
`include "table_selector_cfg.svh"

package table_selector_pkg;

  // One logical value as produced by another function block.
  typedef struct packed {
    logic [`DATA_WIDTH-1:0] value;
    logic error;
    logic available;
  } signal_type;

  // Configuration of one condition.
  typedef struct packed {
    logic [`SOURCE_TYPE_WIDTH-1:0] first_type;
    logic [`SOURCE_NUMBER_WIDTH-1:0] first_number;
    logic [`SOURCE_TYPE_WIDTH-1:0] second_type;
    logic [`SOURCE_NUMBER_WIDTH-1:0] second_number;
    logic [`DATA_WIDTH-1:0] constant_value;
    logic [2:0] operator_code;
  } condition_cfg_type;

  typedef condition_cfg_type [`CONDITION_COUNT-1:0] table_cfg_type;

  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_PROGRAM = 2'b01,
    SEL_RUN = 2'b10
  } sel_state_type;

endpackage

// file: table_selector_test.sv
// Self-checking bench for the table selector: corner and random configurations.
// Assumes the package, the checker bind and the table source model are compiled first.
`include "table_selector_cfg.svh"
module table_selector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic config_write_i = 1'h0;
  logic enable_i = 1'h0;
  logic [2:0] combiner_i [`TABLE_COUNT];
  logic [`TABLE_COUNT-1:0] table_axis_valid_i = 3'h7;
  table_selector_pkg::table_cfg_type table_cfg_i [`TABLE_COUNT];
  table_selector_pkg::signal_type source_i [16];
  table_selector_pkg::signal_type table_i [`TABLE_COUNT];
  table_selector_pkg::signal_type result_o;
  logic [1:0] selected_table_o;
  logic enabled_o;
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 clock_i = ~clock_i;
  table_selector #(.SOURCE_COUNT(16)) u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .config_write_i(config_write_i), .enable_i(enable_i), .table_cfg_i(table_cfg_i),
    .combiner_i(combiner_i), .source_i(source_i), .table_i(table_i),
    .table_axis_valid_i(table_axis_valid_i), .result_o(result_o),
    .selected_table_o(selected_table_o), .enabled_o(enabled_o));
  table_source_model u_tables (.clock_i(clock_i), .table_o(table_i));
  function automatic logic [1:0] cond_result(input table_selector_pkg::condition_cfg_type c);
    table_selector_pkg::signal_type a;
    table_selector_pkg::signal_type b;
    a = source_i[c.first_number];
    b = source_i[c.second_number];
    if (c.second_type == `SOURCE_CONSTANT) b = '{c.constant_value, 1'h0, 1'h1};
    if (c.first_type == `SOURCE_NOT_USED || c.second_type == `SOURCE_NOT_USED
        || !a.available || !b.available) return `RESULT_NOT_APPLICABLE;
    if (a.error || b.error) return `RESULT_ERROR;
    case (c.operator_code)
      `OP_EQUAL: return {1'h0, a.value == b.value};
      `OP_NOT_EQUAL: return {1'h0, a.value != b.value};
      `OP_GREATER: return {1'h0, a.value > b.value};
      `OP_GREATER_EQUAL: return {1'h0, a.value >= b.value};
      `OP_LESS: return {1'h0, a.value < b.value};
      default: return {1'h0, a.value <= b.value};
    endcase
  endfunction
  function automatic logic [1:0] expect_sel();
    logic [1:0] r;
    logic [2:0] t;
    logic [2:0] n;
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 3; c++) begin
        r = cond_result(table_cfg_i[k][c]);
        t[c] = r == `RESULT_TRUE;
        n[c] = t[c] || r == `RESULT_NOT_APPLICABLE;
      end
      case (combiner_i[k])
        `COMBINE_DEFAULT: return k[1:0];
        `COMBINE_AND_ALL: if (&n) return k[1:0];
        `COMBINE_OR_ALL: if (|t) return k[1:0];
        `COMBINE_AND_OR: if ((t[0] && t[1]) || t[2]) return k[1:0];
        default: if ((t[0] || t[1]) && t[2]) return k[1:0];
      endcase
    end
    return `NO_TABLE;
  endfunction
  task automatic check_out(input logic [3:0] exp, input string what);
    checks_done++;
    if ({enabled_o, selected_table_o, result_o.available} !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what,
        {enabled_o, selected_table_o, result_o.available}, exp);
    end
  endtask
  task automatic check_value(input table_selector_pkg::signal_type exp, input string what);
    checks_done++;
    if ({result_o.value, result_o.error} !== {exp.value, exp.error}) begin
      n_mismatch++;
      $display("mismatch at %0t: %s value %h expected %h", $time, what, result_o.value,
        exp.value);
    end
  endtask
  // Called just after an edge; inputs stay put until the outputs are sampled.
  task automatic apply(input logic en, input string name);
    logic [1:0] sel;
    table_selector_pkg::signal_type seen;
    sel = en ? expect_sel() : `NO_TABLE;
    config_write_i = 1'h1;
    enable_i = en;
    @(posedge clock_i);
    #1 config_write_i = 1'h0;
    // The tables move just after each edge, so this is what the selector loads now.
    @(posedge clock_i);
    seen = '0;
    if (sel != `NO_TABLE) seen = table_i[sel];
    #1 check_out({en, sel, sel != `NO_TABLE && table_axis_valid_i[sel]}, name);
    if (sel != `NO_TABLE) check_value(seen, name);
    $display("test %s done", name);
  endtask
  task automatic randomize_inputs();
    foreach (source_i[i]) source_i[i] = '{16'($urandom_range(3)), $urandom_range(7) == 0,
      $urandom_range(7) != 0};
    foreach (table_cfg_i[k]) begin
      for (int c = 0; c < 3; c++) table_cfg_i[k][c] = '{($urandom_range(5) == 0) ? 4'h0 : 4'h2,
        4'($urandom_range(15)), 4'($urandom_range(2)), 4'($urandom_range(15)),
        16'($urandom_range(3)), 3'($urandom_range(5))};
      combiner_i[k] = 3'($urandom_range(4, k == 2 ? 0 : 1));
    end
    table_axis_valid_i = 3'($urandom);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    foreach (table_cfg_i[k]) begin
      table_cfg_i[k] = '0;
      combiner_i[k] = `COMBINE_AND_ALL;
    end
    combiner_i[2] = `COMBINE_DEFAULT;
    foreach (source_i[i]) source_i[i] = '0;
    void'($urandom(22));
    repeat (20) @(posedge clock_i);
    #1 sys_rst_i = 1'h0;
    @(posedge clock_i);
    #1 check_out(4'h6, "reset");
    $display("test reset done");
    apply(1'h1, "unused");
    foreach (combiner_i[k]) combiner_i[k] = `COMBINE_OR_ALL;
    apply(1'h1, "none");
    repeat (60) begin
      randomize_inputs();
      apply($urandom_range(9) != 0, "random");
    end
    apply(1'h0, "off");
    end_of_test();
  end
  // Some 64 tests, the reset one of 21 cycles and the rest of two cycles each; the limit leaves a wide margin.
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule

// file: table_source_model.sv
// Model of the three upstream lookup tables feeding the selector.
// Assumes the bench clock; outputs move just after each rising edge.
`include "table_selector_cfg.svh"
module table_source_model (
  // Clock
  input wire logic clock_i,
  // Table outputs
  output table_selector_pkg::signal_type table_o [`TABLE_COUNT]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] step_reg = 16'h0000;
  // The values change every cycle, so a stale or scaled output cannot pass for a mirror.
  always @(posedge clock_i) begin
    step_reg <= #1 step_reg + 16'h0001;
  end
  for (genvar i = 0; i < `TABLE_COUNT; i++) begin : g_table
    assign table_o[i] = '{step_reg + 16'(i * 16'h1000), 1'h0, 1'h1};
  end
endmodule
